// ---- rtl/gpm_port_mux.sv ----
// Summary of operation
// RULE1: A direction bit of 1 puts that pin's driver in high impedance so the pin is an input.
// RULE2: A direction bit of 0 drives the pin with its output latch bit.
// RULE3: Reads and read-modify-writes of a latch register see the latched value, not the pins.
// RULE4: The second port is eight bits wide and each pin's direction is set on its own.
// RULE5: After reset the seven lower second-port pins are analog inputs and read as zero.
// RULE6: Software turns off the converter's analog selection before digital input use.
// RULE7: Second-port pins one and two carry comparator signals when comparator control selects it.
// RULE8: An active external memory bus drives address/data bits 13 to 15 on the upper first-port pins.
// RULE9: During external memory reads those pins are sampled as data bits 13 to 15.
// RULE10: PWM channels on first-port pins five and six need direction 0 and may float on shutdown.
// RULE11: First-port pin seven carries unit two's compare output at direction 0, its capture at 1.
// RULE12: Unit two uses pin seven only when its pin-select bit is cleared.
// RULE13: The external memory functions exist only when the build parameter enables them.
// RULE14: Software writes the converter configuration to switch second-port pins to digital.
// RULE15: A read of a port register returns sampled pins and a write updates the output latch.
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`include "gpm_regs.svh"

module gpm_port_mux #(
    parameter bit HAS_EXT_MEM = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] first_port_pin_in,
    output gpm_pkg::gpm_pad_s first_port_pad,
    input wire logic [7:0] second_port_pin_in,
    output gpm_pkg::gpm_pad_s second_port_pad,
    input wire gpm_pkg::gpm_extmem_s ext_mem,
    output logic [2:0] ext_mem_data_in,
    input wire gpm_pkg::gpm_pwm1_s pwm1,
    input wire gpm_pkg::gpm_ccu2_s ccu2,
    output logic ccu2_capture_in,
    input wire logic comparator1_out,
    input wire logic comparator2_out,
    output logic [6:0] analog_select
);

    logic [7:0] fp_latch_q;
    logic [7:0] fp_dir_q;
    logic [7:0] sp_latch_q;
    logic [7:0] sp_dir_q;
    logic [6:0] analog_q;
    logic [1:0] cmp_q;
    logic ccu2_sel_q;
    logic wr_q;
    logic rd_q;
    logic [7:0] addr_q;

    logic [7:0] fp_sync;
    logic [7:0] sp_sync;

    gpm_pin_sync #(.W(8)) u_fp_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(first_port_pin_in),
        .pin_sync(fp_sync)
    );

    gpm_pin_sync #(.W(8)) u_sp_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(second_port_pin_in),
        .pin_sync(sp_sync)
    );

    // Bus address phase
    wire accept = hsel & htrans[1] & hready;
    wire [7:0] wbyte = hwdata[7:0];
    wire wr_fp_pins = wr_q && (addr_q == `GPM_OFF_FP_PINS);
    wire wr_fp_latch = wr_q && (addr_q == `GPM_OFF_FP_LATCH);
    wire wr_fp_dir = wr_q && (addr_q == `GPM_OFF_FP_DIR);
    wire wr_sp_pins = wr_q && (addr_q == `GPM_OFF_SP_PINS);
    wire wr_sp_latch = wr_q && (addr_q == `GPM_OFF_SP_LATCH);
    wire wr_sp_dir = wr_q && (addr_q == `GPM_OFF_SP_DIR);
    wire wr_conv = wr_q && (addr_q == `GPM_OFF_CONV_CFG);
    wire wr_cmp = wr_q && (addr_q == `GPM_OFF_CMP_CTRL);
    wire wr_sel = wr_q && (addr_q == `GPM_OFF_PIN_SEL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_q <= accept & hwrite;
            rd_q <= accept & ~hwrite;
            if (accept) begin
                addr_q <= {haddr[7:2], 2'h0};
            end
        end
    end

    // Register writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fp_latch_q <= `GPM_RST_LATCH;
            fp_dir_q <= `GPM_RST_DIR;
            sp_latch_q <= `GPM_RST_LATCH;
            sp_dir_q <= `GPM_RST_DIR;
            analog_q <= `GPM_RST_ANALOG; // [RULE5]
            cmp_q <= `GPM_RST_CMP;
            ccu2_sel_q <= `GPM_RST_SEL;
        end else begin
            if (wr_fp_pins || wr_fp_latch) begin
                fp_latch_q <= wbyte; // [RULE15] [RULE3]
            end
            if (wr_fp_dir) begin
                fp_dir_q <= wbyte;
            end
            if (wr_sp_pins || wr_sp_latch) begin
                sp_latch_q <= wbyte; // [RULE15] [RULE3]
            end
            if (wr_sp_dir) begin
                sp_dir_q <= wbyte; // [RULE4]
            end
            if (wr_conv) begin
                analog_q <= wbyte[6:0]; // [RULE14] [RULE6]
            end
            if (wr_cmp) begin
                cmp_q <= wbyte[1:0];
            end
            if (wr_sel) begin
                ccu2_sel_q <= wbyte[`GPM_CCU2_SEL_BIT];
            end
        end
    end

    // Pin read values
    wire [7:0] fp_read = fp_sync; // [RULE15]
    wire [7:0] sp_read = {sp_sync[7], sp_sync[6:0] & ~analog_q}; // [RULE5]

    // Read data, unmapped offsets read as zero
    wire [7:0] rbyte =
        (addr_q == `GPM_OFF_FP_PINS) ? fp_read :
        (addr_q == `GPM_OFF_FP_LATCH) ? fp_latch_q : // [RULE3]
        (addr_q == `GPM_OFF_FP_DIR) ? fp_dir_q :
        (addr_q == `GPM_OFF_SP_PINS) ? sp_read :
        (addr_q == `GPM_OFF_SP_LATCH) ? sp_latch_q : // [RULE3]
        (addr_q == `GPM_OFF_SP_DIR) ? sp_dir_q :
        (addr_q == `GPM_OFF_CONV_CFG) ? {1'b0, analog_q} :
        (addr_q == `GPM_OFF_CMP_CTRL) ? {6'h00, cmp_q} :
        (addr_q == `GPM_OFF_PIN_SEL) ? {7'h00, ccu2_sel_q} : 8'h00;

    assign hrdata = rd_q ? {24'h000000, rbyte} : 32'h00000000;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // First port override masks, highest priority first
    wire ext_on = HAS_EXT_MEM && ext_mem.active; // [RULE13]
    wire [7:0] ext_m = {{3{ext_on}}, 5'h00}; // [RULE8]
    wire [7:0] ext_v = {ext_mem.dout, 5'h00};
    wire [7:0] pwm_m = {1'b0, pwm1.b_en & ~fp_dir_q[6], pwm1.c_en & ~fp_dir_q[5], 5'h00}; // [RULE10]
    wire [7:0] pwm_v = {1'b0, pwm1.b, pwm1.c, 5'h00};
    wire ccu2_routed = ccu2.en & ~ccu2_sel_q; // [RULE12]
    wire [7:0] ccu_m = {ccu2_routed & ~fp_dir_q[7], 7'h00}; // [RULE11]
    wire [7:0] ccu_v = {ccu2.out, 7'h00};
    wire [7:0] fp_rest = ~ext_m & ~pwm_m;

    assign first_port_pad.dout = (ext_m & ext_v) | (~ext_m & pwm_m & pwm_v)
        | (fp_rest & ccu_m & ccu_v) | (fp_rest & ~ccu_m & fp_latch_q); // [RULE2] [RULE8]
    assign first_port_pad.oe_n = ~ext_m & ((pwm_m & {8{pwm1.shutdown}})
        | (~pwm_m & fp_dir_q)); // [RULE1] [RULE10]

    assign ext_mem_data_in = (HAS_EXT_MEM && ext_mem.read) ? fp_sync[7:5] : 3'h0; // [RULE9]
    assign ccu2_capture_in = ccu2_routed & fp_dir_q[7] & fp_sync[7]; // [RULE11]

    // Second port with comparator outputs on pins one and two
    wire [7:0] cmp_m = {5'h00, cmp_q[`GPM_CMP1_OUT_EN_BIT] & ~sp_dir_q[2],
        cmp_q[`GPM_CMP2_OUT_EN_BIT] & ~sp_dir_q[1], 1'b0}; // [RULE7]
    wire [7:0] cmp_v = {5'h00, comparator1_out, comparator2_out, 1'b0};

    assign second_port_pad.dout = (cmp_m & cmp_v) | (~cmp_m & sp_latch_q); // [RULE2]
    assign second_port_pad.oe_n = sp_dir_q; // [RULE1] [RULE4]
    assign analog_select = analog_q;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    dir_input_a: assert property ( // [RULE1]
        sp_dir_q[3] |-> second_port_pad.oe_n[3])
        else $error("input pin is driven");

    fp_input_a: assert property ( // [RULE1]
        !ext_on && fp_dir_q[0] |-> first_port_pad.oe_n[0])
        else $error("first port input pin is driven");

    drive_latch_a: assert property ( // [RULE2]
        !sp_dir_q[5] |-> !second_port_pad.oe_n[5]
        && second_port_pad.dout[5] == sp_latch_q[5])
        else $error("output pin does not show latch");

    fp_drive_latch_a: assert property ( // [RULE2]
        !fp_dir_q[1] |-> !first_port_pad.oe_n[1]
        && first_port_pad.dout[1] == fp_latch_q[1])
        else $error("first port output pin does not show latch");

    latch_read_a: assert property ( // [RULE3]
        rd_q && addr_q == `GPM_OFF_SP_LATCH |-> hrdata[7:0] == sp_latch_q)
        else $error("latch read returns wrong value");

    latch_write_a: assert property ( // [RULE3]
        accept && hwrite && haddr[7:0] == `GPM_OFF_FP_LATCH
        ##1 1'b1 |=> fp_latch_q == $past(hwdata[7:0]))
        else $error("latch write not applied");

    dir_write_a: assert property ( // [RULE4]
        accept && hwrite && haddr[7:0] == `GPM_OFF_SP_DIR
        ##1 1'b1 |=> second_port_pad.oe_n == $past(hwdata[7:0]))
        else $error("direction write not applied per pin");

    analog_zero_a: assert property ( // [RULE5]
        rd_q && addr_q == `GPM_OFF_SP_PINS |-> (hrdata[6:0] & analog_q) == 7'h00)
        else $error("analog pin reads nonzero");

    pin7_digital_a: assert property ( // [RULE5]
        rd_q && addr_q == `GPM_OFF_SP_PINS |-> hrdata[7] == sp_sync[7])
        else $error("second port pin seven read mismatch");

    cmp_out_a: assert property ( // [RULE7]
        cmp_q[`GPM_CMP2_OUT_EN_BIT] && !sp_dir_q[1]
        |-> second_port_pad.dout[1] == comparator2_out)
        else $error("comparator output missing");

    cmp1_out_a: assert property ( // [RULE7]
        cmp_q[`GPM_CMP1_OUT_EN_BIT] && !sp_dir_q[2]
        |-> second_port_pad.dout[2] == comparator1_out)
        else $error("first comparator output missing");

    ext_drive_a: assert property ( // [RULE8]
        HAS_EXT_MEM && ext_mem.active
        |-> first_port_pad.oe_n[7:5] == 3'h0
        && first_port_pad.dout[7:5] == ext_mem.dout)
        else $error("external bus not on upper pins");

    ext_over_pwm_a: assert property ( // [RULE8]
        ext_on && pwm1.c_en && !fp_dir_q[5]
        |-> first_port_pad.dout[5] == ext_mem.dout[0])
        else $error("pwm overrides external bus");

    ext_dir_a: assert property ( // [RULE8]
        ext_on && fp_dir_q[7] |-> !first_port_pad.oe_n[7])
        else $error("external bus blocked by direction");

    ext_sample_a: assert property ( // [RULE9]
        HAS_EXT_MEM && ext_mem.read |-> ext_mem_data_in == fp_sync[7:5])
        else $error("external read data mismatch");

    ext_idle_a: assert property ( // [RULE9]
        !ext_mem.read |-> ext_mem_data_in == 3'h0)
        else $error("external read data outside read");

    pwm_float_a: assert property ( // [RULE10]
        !ext_on && pwm1.c_en && !fp_dir_q[5] && pwm1.shutdown
        |-> first_port_pad.oe_n[5])
        else $error("pwm pin not floating in shutdown");

    pwm_drive_a: assert property ( // [RULE10]
        !ext_on && pwm1.b_en && !fp_dir_q[6] && !pwm1.shutdown
        |-> !first_port_pad.oe_n[6] && first_port_pad.dout[6] == pwm1.b)
        else $error("pwm channel not on its pin");

    pwm_dir_a: assert property ( // [RULE10]
        !ext_on && fp_dir_q[6] |-> first_port_pad.oe_n[6])
        else $error("pwm drives an input pin");

    ccu2_drive_a: assert property ( // [RULE11]
        !ext_on && ccu2.en && !ccu2_sel_q && !fp_dir_q[7]
        |-> !first_port_pad.oe_n[7] && first_port_pad.dout[7] == ccu2.out)
        else $error("unit two output not on pin seven");

    ccu2_capture_a: assert property ( // [RULE11]
        ccu2.en && !ccu2_sel_q && fp_dir_q[7] |-> ccu2_capture_in == fp_sync[7])
        else $error("unit two capture input mismatch");

    ccu2_route_a: assert property ( // [RULE12]
        !ext_on && ccu2_sel_q
        |-> !ccu2_capture_in && first_port_pad.dout[7] == fp_latch_q[7])
        else $error("unit two routed while deselected");

    pins_write_a: assert property ( // [RULE15]
        accept && hwrite && haddr[7:0] == `GPM_OFF_FP_PINS
        ##1 1'b1 |=> fp_latch_q == $past(hwdata[7:0]))
        else $error("pin register write missed latch");

    sp_pins_write_a: assert property ( // [RULE15]
        accept && hwrite && haddr[7:0] == `GPM_OFF_SP_PINS
        ##1 1'b1 |=> sp_latch_q == $past(hwdata[7:0]))
        else $error("second pin register write missed latch");

    fp_pin_read_a: assert property ( // [RULE15]
        rd_q && addr_q == `GPM_OFF_FP_PINS |-> hrdata[7:0] == fp_sync)
        else $error("pin register read mismatch");

endmodule : gpm_port_mux

// ---- rtl/gpm_regs.svh ----
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH

// Register byte offsets
`define GPM_OFF_FP_PINS 8'h00
`define GPM_OFF_FP_LATCH 8'h04
`define GPM_OFF_FP_DIR 8'h08
`define GPM_OFF_SP_PINS 8'h0c
`define GPM_OFF_SP_LATCH 8'h10
`define GPM_OFF_SP_DIR 8'h14
`define GPM_OFF_CONV_CFG 8'h18
`define GPM_OFF_CMP_CTRL 8'h1c
`define GPM_OFF_PIN_SEL 8'h20

// Field positions
`define GPM_CMP2_OUT_EN_BIT 0
`define GPM_CMP1_OUT_EN_BIT 1
`define GPM_CCU2_SEL_BIT 0

// Reset values
`define GPM_RST_LATCH 8'h00
`define GPM_RST_DIR 8'hff
`define GPM_RST_ANALOG 7'h7f
`define GPM_RST_CMP 2'h0
`define GPM_RST_SEL 1'h0
`define GPM_RST_SYNC 1'h0

`endif

// ---- rtl/gpm_pkg.sv ----
package gpm_pkg;

    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe_n;
    } gpm_pad_s;

    typedef struct packed {
        logic active;
        logic read;
        logic [2:0] dout;
    } gpm_extmem_s;

    typedef struct packed {
        logic c_en;
        logic b_en;
        logic c;
        logic b;
        logic shutdown;
    } gpm_pwm1_s;

    typedef struct packed {
        logic en;
        logic out;
    } gpm_ccu2_s;

endpackage : gpm_pkg

// ---- rtl/gpm_pin_sync.sv ----
`timescale 1ns/100ps
`include "gpm_regs.svh"

module gpm_pin_sync #(
    parameter int W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] val_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_q[i] <= `GPM_RST_SYNC;
                    s2_q[i] <= `GPM_RST_SYNC;
                    s3_q[i] <= `GPM_RST_SYNC;
                    val_q[i] <= `GPM_RST_SYNC;
                end else begin
                    s1_q[i] <= pin_in[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    // Accept a change only when stages two and three agree
                    if (s2_q[i] == s3_q[i]) begin
                        val_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

    assign pin_sync = val_q;

endmodule : gpm_pin_sync

// ---- verification/gpm_pin_model.sv ----
`timescale 1ns/100ps

module gpm_pin_model (
    input wire gpm_pkg::gpm_pad_s first_port_pad,
    input wire gpm_pkg::gpm_pad_s second_port_pad,
    input wire logic [7:0] fp_ext,
    input wire logic [7:0] sp_ext,
    output logic [7:0] first_port_pin_in,
    output logic [7:0] second_port_pin_in
);
    // Driven pins follow the pad, released pins follow the board
    assign first_port_pin_in = (first_port_pad.oe_n & fp_ext) |
        (~first_port_pad.oe_n & first_port_pad.dout);
    assign second_port_pin_in = (second_port_pad.oe_n & sp_ext) |
        (~second_port_pad.oe_n & second_port_pad.dout);
endmodule : gpm_pin_model

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`include "gpm_regs.svh"

module testbench;
    logic hclk = 1'h0;
    logic hresetn = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] fp_in;
    logic [7:0] sp_in;
    logic [7:0] fp_ext = 8'hff;
    logic [7:0] sp_ext = 8'hff;
    logic [2:0] xm_din;
    logic cap_in;
    logic cmp1 = 1'h0;
    logic cmp2 = 1'h0;
    logic [6:0] an_sel;
    logic [7:0] rv;
    gpm_pkg::gpm_pad_s fp_pad;
    gpm_pkg::gpm_pad_s sp_pad;
    gpm_pkg::gpm_extmem_s xm = 5'h0;
    gpm_pkg::gpm_pwm1_s pwm = 5'h0;
    gpm_pkg::gpm_ccu2_s cc = 2'h0;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;

    always #50 hclk = ~hclk;

    gpm_port_mux dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .first_port_pin_in(fp_in),
        .first_port_pad(fp_pad), .second_port_pin_in(sp_in), .second_port_pad(sp_pad),
        .ext_mem(xm), .ext_mem_data_in(xm_din), .pwm1(pwm), .ccu2(cc),
        .ccu2_capture_in(cap_in), .comparator1_out(cmp1), .comparator2_out(cmp2),
        .analog_select(an_sel));

    gpm_pin_model pm_u (.first_port_pad(fp_pad), .second_port_pad(sp_pad), .fp_ext(fp_ext),
        .sp_ext(sp_ext), .first_port_pin_in(fp_in), .second_port_pin_in(sp_in));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            $display("unexpected at %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'h1);
        rv = hrdata[7:0];
        #1;
    endtask : bus

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        #1;
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic t_reset();
        bus(`GPM_OFF_FP_DIR, 1'h0, 8'h0);
        chk(rv, 8'hff);
        chk(fp_pad.oe_n & sp_pad.oe_n, 8'hff);
        bus(`GPM_OFF_SP_PINS, 1'h0, 8'h0);
        chk(rv, 8'h80);
        chk(8'(an_sel), 8'h7f);
        chk(8'(hresp), 8'h00);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_dir();
        bus(`GPM_OFF_FP_LATCH, 1'h1, 8'ha5);
        bus(`GPM_OFF_FP_DIR, 1'h1, 8'h0f);
        chk(fp_pad.oe_n, 8'h0f);
        chk(fp_pad.dout & 8'hf0, 8'ha0);
        bus(`GPM_OFF_SP_LATCH, 1'h1, 8'h3c);
        bus(`GPM_OFF_SP_DIR, 1'h1, 8'h5a);
        chk(sp_pad.oe_n, 8'h5a);
        chk(sp_pad.dout & 8'ha5, 8'h24);
        repeat (5) @(posedge hclk);
        bus(`GPM_OFF_FP_PINS, 1'h0, 8'h0);
        chk(rv, 8'haf);
        $display("t_dir done");
    endtask : t_dir

    task automatic t_latch();
        bus(`GPM_OFF_FP_PINS, 1'h1, 8'h5c);
        bus(`GPM_OFF_FP_DIR, 1'h1, 8'hff);
        fp_ext <= 8'h00;
        repeat (5) @(posedge hclk);
        bus(`GPM_OFF_FP_LATCH, 1'h0, 8'h0);
        chk(rv, 8'h5c);
        bus(`GPM_OFF_FP_PINS, 1'h0, 8'h0);
        chk(rv, 8'h00);
        $display("t_latch done");
    endtask : t_latch

    task automatic t_analog();
        bus(`GPM_OFF_SP_DIR, 1'h1, 8'hff);
        sp_ext <= 8'h55;
        bus(`GPM_OFF_CONV_CFG, 1'h1, 8'h0f);
        repeat (5) @(posedge hclk);
        bus(`GPM_OFF_SP_PINS, 1'h0, 8'h0);
        chk(rv, 8'h50);
        bus(`GPM_OFF_CONV_CFG, 1'h1, 8'h00);
        bus(`GPM_OFF_SP_PINS, 1'h0, 8'h0);
        chk(rv, 8'h55);
        $display("t_analog done");
    endtask : t_analog

    task automatic t_comp();
        bus(`GPM_OFF_SP_PINS, 1'h1, 8'h02);
        bus(`GPM_OFF_SP_DIR, 1'h1, 8'h00);
        bus(`GPM_OFF_SP_LATCH, 1'h0, 8'h0);
        chk(rv, 8'h02);
        cmp1 <= 1'h1;
        cmp2 <= 1'h0;
        bus(`GPM_OFF_CMP_CTRL, 1'h1, 8'h03);
        chk(8'(sp_pad.dout[2:1]), 8'h02);
        bus(`GPM_OFF_CMP_CTRL, 1'h1, 8'h00);
        chk(8'(sp_pad.dout[2:1]), 8'h01);
        $display("t_comp done");
    endtask : t_comp

    task automatic t_ext();
        xm <= 5'h15;
        @(posedge hclk);
        chk(8'(fp_pad.oe_n[7:5]), 8'h00);
        chk(8'(fp_pad.dout[7:5]), 8'h05);
        xm <= 5'h08;
        fp_ext <= 8'hc0;
        repeat (5) @(posedge hclk);
        chk(8'(xm_din), 8'h06);
        xm <= 5'h00;
        $display("t_ext done");
    endtask : t_ext

    task automatic t_pwm();
        bus(`GPM_OFF_FP_LATCH, 1'h1, 8'h00);
        bus(`GPM_OFF_FP_DIR, 1'h1, 8'h00);
        pwm <= 5'h1c;
        cc <= 2'h3;
        @(posedge hclk);
        chk(8'(fp_pad.dout[7:5]), 8'h05);
        xm <= 5'h12;
        @(posedge hclk);
        chk(8'(fp_pad.dout[7:5]), 8'h02);
        xm <= 5'h00;
        pwm <= 5'h1d;
        @(posedge hclk);
        chk(8'(fp_pad.oe_n[6:5]), 8'h03);
        bus(`GPM_OFF_PIN_SEL, 1'h1, 8'h01);
        chk(8'(fp_pad.dout[7]), 8'h00);
        bus(`GPM_OFF_PIN_SEL, 1'h1, 8'h00);
        bus(`GPM_OFF_FP_DIR, 1'h1, 8'h80);
        fp_ext <= 8'h80;
        repeat (5) @(posedge hclk);
        chk(8'(cap_in), 8'h01);
        bus(`GPM_OFF_PIN_SEL, 1'h1, 8'h01);
        chk(8'(cap_in), 8'h00);
        $display("t_pwm done");
    endtask : t_pwm

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (5) @(posedge hclk);
        t_reset();
        t_dir();
        t_latch();
        t_analog();
        t_comp();
        t_ext();
        t_pwm();
        end_sim();
    end
endmodule : testbench
